// File: hdl/acpr_regs.sv
// APB register slice holding compare value and analog pin overrides.
// Summary of operation
// (RULE1) High compare register low nibble holds bits 11:8
// (RULE2) High compare bits 7:4 read zero, ignore writes
// (RULE3) Upper nibble compared only after 12-bit conversions
// (RULE4) Low compare register holds result bits 7:0
// (RULE5) Pin register low bit n governs channel n
// (RULE6) Override bit one removes port control from pin
// (RULE7) High pin register bits 3:0 govern channels 11:8
// (RULE8) Overridden pin: output hi-z, input off, no pull
// (RULE9) Compare runs only while compare enable set
// (RULE10) Compare value write aborts running conversions
// (RULE11) Registers reset to zero and read back writes
module acpr_regs (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [acpr_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Conversion engine side
	input wire logic compare_enable,
	input wire acpr_pkg::acpr_result_s result,
	output logic conv_abort,
	output acpr_pkg::acpr_cmp_s cmp_outcome,
	// Port override side
	output acpr_pkg::acpr_pin_ctl_s pin_ctl
);

	// ==========================================================
	// Storage
	logic [acpr_pkg::HI_BITS-1:0] cmp_high_r;
	logic [acpr_pkg::LO_BITS-1:0] cmp_low_r;
	logic [7:0] pin_low_r;
	logic [3:0] pin_high_r;
	logic [acpr_pkg::PIN_BITS-1:0] pin_all;
	logic wr_cycle;
	logic rd_cycle;
	acpr_pkg::acpr_cmp_s cmp_q;

	function automatic logic known_addr(input logic [17:0] a);
		known_addr = (a == acpr_pkg::ADDR_CMP_HIGH)
			|| (a == acpr_pkg::ADDR_CMP_LOW)
			|| (a == acpr_pkg::ADDR_PIN_LOW)
			|| (a == acpr_pkg::ADDR_PIN_HIGH)
			|| (a == acpr_pkg::ADDR_CMP_STATUS);
	endfunction : known_addr

	// Setup phase is the only wait: pready rises in the access phase.
	assign wr_cycle = psel && penable && pready && pwrite;
	assign rd_cycle = psel && !penable && !pwrite;
	assign pin_all = {pin_high_r, pin_low_r}; // [RULE5] [RULE7]

	// ==========================================================
	// Writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_high_r <= acpr_pkg::CMP_HIGH_RST; // [RULE11]
			cmp_low_r <= acpr_pkg::CMP_LOW_RST;
			pin_low_r <= acpr_pkg::PIN_LOW_RST;
			pin_high_r <= acpr_pkg::PIN_HIGH_RST;
		end else if (wr_cycle) begin
			unique case (paddr)
				acpr_pkg::ADDR_CMP_HIGH: cmp_high_r <= pwdata[3:0]; // [RULE1] [RULE2]
				acpr_pkg::ADDR_CMP_LOW: cmp_low_r <= pwdata[7:0]; // [RULE4]
				acpr_pkg::ADDR_PIN_LOW: pin_low_r <= pwdata[7:0]; // [RULE5]
				acpr_pkg::ADDR_PIN_HIGH: pin_high_r <= pwdata[3:0]; // [RULE7]
				default: ;
			endcase
		end
	end

	// A compare value change invalidates any conversion in flight.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conv_abort <= 1'b0;
		end else begin
			conv_abort <= wr_cycle && ((paddr == acpr_pkg::ADDR_CMP_HIGH)
				|| (paddr == acpr_pkg::ADDR_CMP_LOW)); // [RULE10]
		end
	end

	// ==========================================================
	// APB handshake and reads
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !known_addr(paddr);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= acpr_pkg::ZERO_WORD;
		end else if (rd_cycle) begin
			unique case (paddr)
				acpr_pkg::ADDR_CMP_HIGH:
					prdata <= {28'h0000000, cmp_high_r}; // [RULE2] [RULE11]
				acpr_pkg::ADDR_CMP_LOW: prdata <= {24'h000000, cmp_low_r};
				acpr_pkg::ADDR_PIN_LOW: prdata <= {24'h000000, pin_low_r};
				acpr_pkg::ADDR_PIN_HIGH: prdata <= {28'h0000000, pin_high_r};
				acpr_pkg::ADDR_CMP_STATUS:
					prdata <= {29'h00000000, compare_enable, cmp_q.match,
						cmp_q.done};
				default: prdata <= acpr_pkg::ZERO_WORD;
			endcase
		end
	end

	// ==========================================================
	// Pin overrides, registered towards the ports
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_ctl <= '0;
		end else begin
			pin_ctl.out_hiz <= pin_all; // [RULE6] [RULE8]
			pin_ctl.in_disable <= pin_all; // [RULE8]
			pin_ctl.pull_disable <= pin_all; // [RULE8]
		end
	end

	// ==========================================================
	// Compare
	acpr_cmp u_cmp (
		.pclk(pclk),
		.presetn(presetn),
		.compare_enable(compare_enable),
		.compare_bits({cmp_high_r, cmp_low_r}),
		.result(result),
		.outcome(cmp_q)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmp_outcome <= '0;
		end else begin
			cmp_outcome <= cmp_q;
		end
	end

endmodule : acpr_regs

// File: hdl/acpr_pkg.sv
// Package with register map, field layout and carrier types for the block.
package acpr_pkg;

	// ==========================================================
	// Register indices and byte addresses
	localparam logic [15:0] IDX_CMP_HIGH = 16'h0016;
	localparam logic [15:0] IDX_CMP_LOW = 16'h0017;
	localparam logic [15:0] IDX_PIN_LOW = 16'h30ac;
	localparam logic [15:0] IDX_PIN_HIGH = 16'h30ad;
	localparam logic [15:0] IDX_CMP_STATUS = 16'h0018;
	localparam int ADDR_W = 18;
	localparam logic [17:0] ADDR_CMP_HIGH = {IDX_CMP_HIGH, 2'h0};
	localparam logic [17:0] ADDR_CMP_LOW = {IDX_CMP_LOW, 2'h0};
	localparam logic [17:0] ADDR_PIN_LOW = {IDX_PIN_LOW, 2'h0};
	localparam logic [17:0] ADDR_PIN_HIGH = {IDX_PIN_HIGH, 2'h0};
	localparam logic [17:0] ADDR_CMP_STATUS = {IDX_CMP_STATUS, 2'h0};

	// ==========================================================
	// Field layout and reset values
	localparam int HI_BITS = 4;
	localparam int LO_BITS = 8;
	localparam int CMP_BITS = 12;
	localparam int PIN_BITS = 12;
	localparam logic [3:0] CMP_HIGH_RST = 4'h0;
	localparam logic [7:0] CMP_LOW_RST = 8'h00;
	localparam logic [7:0] PIN_LOW_RST = 8'h00;
	localparam logic [3:0] PIN_HIGH_RST = 4'h0;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

	// ==========================================================
	// Result sample from the conversion engine
	typedef struct packed {
		logic valid;
		logic twelve_bit;
		logic [11:0] value;
	} acpr_result_s;

	// Per-pin port override towards the I/O ports
	typedef struct packed {
		logic [11:0] out_hiz;
		logic [11:0] in_disable;
		logic [11:0] pull_disable;
	} acpr_pin_ctl_s;

	// Compare outcome towards the conversion engine
	typedef struct packed {
		logic done;
		logic match;
	} acpr_cmp_s;

endpackage : acpr_pkg

// File: hdl/acpr_cmp.sv
// Compare unit that checks a conversion result against the compare value.
module acpr_cmp (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Configuration
	input wire logic compare_enable,
	input wire logic [acpr_pkg::CMP_BITS-1:0] compare_bits,
	// Result in, outcome out
	input wire acpr_pkg::acpr_result_s result,
	output acpr_pkg::acpr_cmp_s outcome
);

	// ==========================================================
	// Compare stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			outcome <= '0;
		end else begin
			outcome.done <= result.valid && compare_enable; // [RULE9]
			if (result.valid && compare_enable) begin // [RULE9]
				// Upper nibble only takes part after a 12-bit conversion.
				if (result.twelve_bit) begin // [RULE3]
					outcome.match <= (result.value == compare_bits); // [RULE4]
				end else begin
					outcome.match <= (result.value[acpr_pkg::LO_BITS-1:0]
						== compare_bits[acpr_pkg::LO_BITS-1:0]);
				end
			end
		end
	end

endmodule : acpr_cmp

// File: dv/acpr_assertions.sv
// Port checker for the compare and pin override register slice.
module acpr_chk (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus
	input wire logic pwrite,
	input wire logic [acpr_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	// Engine and pins
	input wire logic compare_enable,
	input wire acpr_pkg::acpr_result_s result,
	input wire logic conv_abort,
	input wire acpr_pkg::acpr_cmp_s cmp_outcome,
	input wire acpr_pkg::acpr_pin_ctl_s pin_ctl
);
	// ====================
	// Checks
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic rd;
	logic cw;
	assign rd = pready && !pwrite;
	assign cw = pready && pwrite && (paddr == acpr_pkg::ADDR_CMP_HIGH
		|| paddr == acpr_pkg::ADDR_CMP_LOW);
	hi_zero_a: assert property (
		rd && paddr == acpr_pkg::ADDR_CMP_HIGH |-> prdata[31:4] == 28'h0)
		else $error("high compare reads nonzero upper bits");
	pin_low_a: assert property (
		rd && paddr == acpr_pkg::ADDR_PIN_LOW
		|-> prdata == {24'h0, pin_ctl.out_hiz[7:0]})
		else $error("low pin override differs from readback");
	pin_high_a: assert property (
		rd && paddr == acpr_pkg::ADDR_PIN_HIGH
		|-> prdata == {28'h0, pin_ctl.out_hiz[11:8]})
		else $error("high pin override differs from readback");
	pin_same_a: assert property (
		pin_ctl.out_hiz == pin_ctl.in_disable
		&& pin_ctl.out_hiz == pin_ctl.pull_disable)
		else $error("pin override fields disagree");
	abort_a: assert property (cw |-> ##[1:2] conv_abort)
		else $error("compare write gave no abort");
	abort_one_a: assert property (conv_abort |=> !conv_abort)
		else $error("abort longer than one cycle");
	done_a: assert property (
		result.valid && compare_enable |-> ##2 cmp_outcome.done)
		else $error("enabled compare gave no done");
	no_done_a: assert property (
		result.valid && !compare_enable |-> ##2 !cmp_outcome.done)
		else $error("disabled compare gave done");
endmodule : acpr_chk

// File: dv/acpr_regs_bench.sv
// Self-checking bench for the compare and pin override register slice.
module acpr_regs_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// ====================
	// Signals
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [17:0] paddr = 18'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, conv_abort, compare_enable = 0;
	acpr_pkg::acpr_result_s result = 14'h0;
	acpr_pkg::acpr_cmp_s cmp_outcome;
	acpr_pkg::acpr_pin_ctl_s pin_ctl;
	int errors = 0, checked = 0, cyc = 0;
	typedef struct {logic [17:0] a; logic [31:0] d, e;} acpr_row_s;
	acpr_row_s rows[4] = '{
		'{acpr_pkg::ADDR_CMP_HIGH, 32'hffff_ffff, 32'h0000_000f},
		'{acpr_pkg::ADDR_CMP_LOW, 32'hffff_ffa5, 32'h0000_00a5},
		'{acpr_pkg::ADDR_PIN_LOW, 32'h0000_005a, 32'h0000_005a},
		'{acpr_pkg::ADDR_PIN_HIGH, 32'hffff_ffff, 32'h0000_000f}};
	always #4 pclk = ~pclk;
	acpr_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.compare_enable(compare_enable), .result(result),
		.conv_abort(conv_abort), .cmp_outcome(cmp_outcome),
		.pin_ctl(pin_ctl));
	// ====================
	// Tasks
	task end_sim();
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_sim
	task chk(input logic [35:0] got, input logic [35:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task apb(input logic w, input logic [17:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Look at pready mid-cycle, where it has settled, then finish the
		// transfer at the rising edge that samples it high.
		do @(negedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// The done flag is due two cycles after the result strobe.
	task cmp(input logic en, tw, input logic [11:0] v, input logic [1:0] e);
		@(posedge pclk);
		compare_enable <= en;
		result <= {1'b1, tw, v};
		@(posedge pclk);
		result.valid <= 1'b0;
		@(posedge pclk);
		#1 chk(cmp_outcome, e);
	endtask : cmp
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 2000) begin
			errors++;
			end_sim();
		end
	end
	// ====================
	// Sequence
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			apb(1'b1, rows[i].a, rows[i].d);
			apb(1'b0, rows[i].a, 32'h0);
			chk(rd, rows[i].e);
		end
		chk(pin_ctl, 36'hf5a_f5a_f5a);
		apb(1'b1, 18'h0, 32'hff);
		apb(1'b0, 18'h0, 32'h0);
		chk({err, rd}, {1'b1, 32'h0});
		cmp(1'b1, 1'b1, 12'hfa5, 2'h3);
		cmp(1'b1, 1'b1, 12'h3a5, 2'h2);
		cmp(1'b1, 1'b0, 12'h3a5, 2'h3);
		cmp(1'b0, 1'b1, 12'h000, 2'h1);
		@(posedge pclk);
		presetn <= 1'b0;
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, acpr_pkg::ADDR_CMP_LOW, 32'h0);
		chk(rd, 36'h0);
		chk(pin_ctl, 36'h0);
		end_sim();
	end
endmodule : acpr_regs_bench
bind acpr_regs acpr_chk chk_i (.pclk(pclk), .presetn(presetn),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.compare_enable(compare_enable), .result(result),
	.conv_abort(conv_abort), .cmp_outcome(cmp_outcome), .pin_ctl(pin_ctl));
